// file: rtl/i2m_master_ctrl.sv
/*
 * Two-wire bus master that reads and writes the byte registers of a
 * sensor slave: pointer write, burst write, pointer write plus
 * repeated start and burst read.
 * Assumes open-drain pads with pull-ups outside; the oe outputs pull low.
 */
// Behaviour
// - Data changes only while clock is low
// - Start/stop coded by data edge, clock high
// - Eight bits MSB first, ninth clock acknowledges
// - Transmitter releases, receiver holds ack low
// - Slave not acknowledging: master issues stop
// - Master reading leaves last byte unacknowledged
// - First byte: 7-bit address, then direction
// - Read: write pointer, repeated start, read
// - Clock rate from zero to 400 kHz
// - No access within 20 ms of power-up
// - Never hold both lines low 10 ms
// - Event pin stays high until host access
`timescale 1ns/1ps
`default_nettype none
module i2m_master_ctrl #(
    parameter int QTR_CYC = i2m_pkg::QTR_CYC,
    parameter int PWRUP_CYC = i2m_pkg::PWRUP_CYC,
    parameter int BOTHLOW_CYC = i2m_pkg::BOTHLOW_CYC,
    parameter int LEN_W = 4
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Command
    input wire logic cmd_valid_i,
    input wire logic cmd_read_i,
    input wire logic [7:0] cmd_reg_i,
    input wire logic [LEN_W-1:0] cmd_len_i,
    input wire logic [7:0] wr_data_i,
    output logic cmd_ready_o,
    output logic busy_o,
    output logic wr_take_o,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic done_o,
    output logic nack_o,
    // Serial clock pad
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    // Serial data pad
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Sensor event pin
    input wire logic evt_pin_i,
    output logic evt_o
);
    localparam int QW = $clog2(QTR_CYC + 1);
    localparam int PW = $clog2(PWRUP_CYC + 2);
    localparam int BW = $clog2(BOTHLOW_CYC + 2);

    // Refuse settings that break the bus timing or leave the length field without bits
    if (QTR_CYC < 2 || LEN_W < 1 || PWRUP_CYC < 1 || BOTHLOW_CYC <= 4 * QTR_CYC) begin : g_chk_size
        $error("i2m_master_ctrl: timing or length parameter too small");
    end
    if (4 * QTR_CYC * i2m_pkg::CLK_PERIOD_NS < i2m_pkg::T_SCL_MIN_NS ||
        2 * QTR_CYC * i2m_pkg::CLK_PERIOD_NS < i2m_pkg::T_LOW_MIN_NS) begin : g_chk_rate
        $error("i2m_master_ctrl: serial clock would run too fast");
    end

    i2m_pins_if pins ();

    i2m_pin_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .evt_i(evt_pin_i),
        .pins(pins.src)
    );

    i2m_pkg::i2m_state_t st;
    i2m_pkg::i2m_step_t step;
    logic [QW-1:0] qcnt;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] tx;
    logic [7:0] rx;
    logic ack_in;
    logic rd_mode;
    logic [7:0] reg_addr;
    logic [LEN_W-1:0] left;
    logic [PW-1:0] pwr_cnt;
    logic active;
    logic stall;
    logic tick;
    logic ph_end;
    logic byte_end;
    logic last;

    // Phase bookkeeping
    assign active = (st == i2m_pkg::I2M_START) || (st == i2m_pkg::I2M_BYTE) ||
                    (st == i2m_pkg::I2M_STOP);
    assign stall = (q == 2'h1) && !pins.scl;
    assign tick = (qcnt == QW'(QTR_CYC - 1));
    assign ph_end = tick && (q == 2'h3);
    assign byte_end = (st == i2m_pkg::I2M_BYTE) && ph_end && (bitn == i2m_pkg::ACK_BIT);
    assign last = (left <= LEN_W'(1));

    // Quarter-bit timer; waits in quarter 1 while the clock line is still held low by anyone
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !active || stall || tick) begin
            qcnt <= '0;
        end else begin
            qcnt <= qcnt + QW'(1);
        end
    end

    // Quarter index inside the current bit or condition
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !active) begin
            q <= 2'h0;
        end else if (tick) begin
            q <= q + 2'h1;
        end
    end

    // Power-up hold-off before the first command
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pwr_cnt <= '0;
        end else if (st == i2m_pkg::I2M_PWRUP) begin
            pwr_cnt <= pwr_cnt + PW'(1);
        end
    end

    // Sample data at the end of the clock-high phase, last cycle of quarter 2
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rx <= 8'h00;
            ack_in <= 1'b1;
        end else if (st == i2m_pkg::I2M_BYTE && tick && q == 2'h2) begin
            if (bitn == i2m_pkg::ACK_BIT) begin
                ack_in <= pins.sda;
            end else begin
                rx <= {rx[6:0], pins.sda};
            end
        end
    end

    // Pad drive; registered one cycle behind the phase it serves
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            unique case (st)
                i2m_pkg::I2M_PWRUP, i2m_pkg::I2M_IDLE: begin
                    scl_oe_o <= 1'b0;
                    sda_oe_o <= 1'b0;
                end
                i2m_pkg::I2M_START: begin
                    unique case (q)
                        2'h0: sda_oe_o <= 1'b0;
                        2'h1: scl_oe_o <= 1'b0;
                        2'h2: sda_oe_o <= 1'b1;
                        2'h3: scl_oe_o <= 1'b1;
                    endcase
                end
                i2m_pkg::I2M_BYTE: begin
                    unique case (q)
                        2'h0: begin
                            scl_oe_o <= 1'b1;
                            if (bitn == i2m_pkg::ACK_BIT) begin
                                // Ack all read bytes except the last
                                sda_oe_o <= (step == i2m_pkg::I2M_RDATA) && !last;
                            end else begin
                                // Release while the slave sends
                                sda_oe_o <= (step != i2m_pkg::I2M_RDATA) && !tx[7];
                            end
                        end
                        2'h1, 2'h2: scl_oe_o <= 1'b0;
                        2'h3: scl_oe_o <= 1'b1;
                    endcase
                end
                i2m_pkg::I2M_STOP: begin
                    unique case (q)
                        2'h0: begin
                            scl_oe_o <= 1'b1;
                            sda_oe_o <= 1'b1;
                        end
                        2'h1: scl_oe_o <= 1'b0;
                        2'h2: sda_oe_o <= 1'b0;
                        2'h3: sda_oe_o <= 1'b0;
                    endcase
                end
            endcase
        end
    end

    // Pads only ever pull low; high comes from the pull-ups
    always_ff @(posedge clk_sys_i) begin
        scl_o <= 1'b0;
        sda_o <= 1'b0;
    end

    // Event pin level for the user; cleared by a status read
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            evt_o <= 1'b0;
        end else begin
            evt_o <= pins.evt;
        end
    end

    // Transfer sequencer
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st <= i2m_pkg::I2M_PWRUP;
            step <= i2m_pkg::I2M_ADDRW;
            bitn <= 4'h0;
            tx <= 8'h00;
            rd_mode <= 1'b0;
            reg_addr <= 8'h00;
            left <= '0;
            cmd_ready_o <= 1'b0;
            busy_o <= 1'b0;
            wr_take_o <= 1'b0;
            rd_data_o <= 8'h00;
            rd_valid_o <= 1'b0;
            done_o <= 1'b0;
            nack_o <= 1'b0;
        end else begin
            wr_take_o <= 1'b0;
            rd_valid_o <= 1'b0;
            done_o <= 1'b0;
            unique case (st)
                i2m_pkg::I2M_PWRUP: begin
                    if (pwr_cnt == PW'(PWRUP_CYC - 1)) begin
                        st <= i2m_pkg::I2M_IDLE;
                        cmd_ready_o <= 1'b1;
                    end
                end
                i2m_pkg::I2M_IDLE: begin
                    if (cmd_valid_i) begin
                        rd_mode <= cmd_read_i;
                        reg_addr <= cmd_reg_i;
                        left <= cmd_len_i;
                        nack_o <= 1'b0;
                        step <= i2m_pkg::I2M_ADDRW;
                        cmd_ready_o <= 1'b0;
                        busy_o <= 1'b1;
                        st <= i2m_pkg::I2M_START;
                    end
                end
                i2m_pkg::I2M_START: begin
                    if (ph_end) begin
                        st <= i2m_pkg::I2M_BYTE;
                        bitn <= 4'h0;
                        // Address first, direction bit last
                        tx <= {i2m_pkg::SLV_ADDR, (step == i2m_pkg::I2M_ADDRR) ?
                               i2m_pkg::DIR_RD : i2m_pkg::DIR_WR};
                    end
                end
                i2m_pkg::I2M_BYTE: begin
                    if (ph_end && bitn != i2m_pkg::ACK_BIT) begin
                        bitn <= bitn + 4'h1;
                        tx <= {tx[6:0], 1'b0};
                    end else if (byte_end) begin
                        bitn <= 4'h0;
                        if (step != i2m_pkg::I2M_RDATA && ack_in) begin
                            // Byte refused by the slave: abort
                            nack_o <= 1'b1;
                            st <= i2m_pkg::I2M_STOP;
                        end else begin
                            unique case (step)
                                i2m_pkg::I2M_ADDRW: begin
                                    step <= i2m_pkg::I2M_REGA;
                                    tx <= reg_addr;
                                end
                                i2m_pkg::I2M_REGA: begin
                                    if (rd_mode) begin
                                        step <= i2m_pkg::I2M_ADDRR;
                                        st <= i2m_pkg::I2M_START;
                                    end else if (left == '0) begin
                                        st <= i2m_pkg::I2M_STOP;
                                    end else begin
                                        step <= i2m_pkg::I2M_WDATA;
                                        tx <= wr_data_i;
                                        wr_take_o <= 1'b1;
                                    end
                                end
                                i2m_pkg::I2M_WDATA: begin
                                    left <= left - LEN_W'(1);
                                    if (last) begin
                                        st <= i2m_pkg::I2M_STOP;
                                    end else begin
                                        tx <= wr_data_i;
                                        wr_take_o <= 1'b1;
                                    end
                                end
                                i2m_pkg::I2M_ADDRR: begin
                                    step <= i2m_pkg::I2M_RDATA;
                                end
                                i2m_pkg::I2M_RDATA: begin
                                    rd_data_o <= rx;
                                    rd_valid_o <= 1'b1;
                                    left <= left - LEN_W'(1);
                                    if (last) begin
                                        st <= i2m_pkg::I2M_STOP;
                                    end
                                end
                            endcase
                        end
                    end
                end
                i2m_pkg::I2M_STOP: begin
                    if (ph_end) begin
                        st <= i2m_pkg::I2M_IDLE;
                        done_o <= 1'b1;
                        busy_o <= 1'b0;
                        cmd_ready_o <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Helper counters read only by the checks below
    logic [3:0] rise_cnt;
    logic [BW-1:0] both_low;
    logic [QW+1:0] hi_cnt;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i || byte_end) begin
            rise_cnt <= 4'h0;
        end else if (st == i2m_pkg::I2M_BYTE && tick && q == 2'h1) begin
            rise_cnt <= rise_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !(scl_oe_o && sda_oe_o)) begin
            both_low <= '0;
        end else begin
            both_low <= both_low + BW'(1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i || scl_oe_o || !active) begin
            hi_cnt <= '0;
        end else begin
            hi_cnt <= hi_cnt + (QW+2)'(1);
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    sequence s_stop_flagged;
        (st == i2m_pkg::I2M_STOP && nack_o) ##1 (st == i2m_pkg::I2M_STOP && nack_o);
    endsequence

    sequence s_restart;
        $past(st) == i2m_pkg::I2M_BYTE ##0 st == i2m_pkg::I2M_START;
    endsequence

    data_stable_a: assert property (
        st == i2m_pkg::I2M_BYTE && !scl_oe_o && !$past(scl_oe_o) |-> $stable(sda_oe_o))
        else $error("data moved while clock high");

    start_cond_a: assert property (
        $rose(sda_oe_o) && !scl_oe_o |-> st == i2m_pkg::I2M_START)
        else $error("data fell with clock high outside start");

    stop_cond_a: assert property (
        $fell(sda_oe_o) && !scl_oe_o |-> st == i2m_pkg::I2M_STOP)
        else $error("data rose with clock high outside stop");

    idle_high_a: assert property (
        st == i2m_pkg::I2M_IDLE |-> !scl_oe_o && !sda_oe_o)
        else $error("bus not released while idle");

    nine_clocks_a: assert property (
        byte_end |-> rise_cnt == i2m_pkg::BITS_PER_BYTE)
        else $error("byte did not take nine clocks");

    tx_release_a: assert property (
        st == i2m_pkg::I2M_BYTE && bitn == i2m_pkg::ACK_BIT && q == 2'h2 &&
        step != i2m_pkg::I2M_RDATA |-> !sda_oe_o)
        else $error("data held during slave ack");

    rx_ack_a: assert property (
        st == i2m_pkg::I2M_BYTE && bitn == i2m_pkg::ACK_BIT && q == 2'h2 &&
        step == i2m_pkg::I2M_RDATA |-> sda_oe_o == !last)
        else $error("wrong ack on read byte");

    nack_stop_a: assert property (
        byte_end && step != i2m_pkg::I2M_RDATA && ack_in |=> s_stop_flagged)
        else $error("refused byte not followed by stop");

    addr_byte_a: assert property (
        st == i2m_pkg::I2M_BYTE && $past(st) == i2m_pkg::I2M_START |->
        tx[7:1] == i2m_pkg::SLV_ADDR && tx[0] == (step == i2m_pkg::I2M_ADDRR))
        else $error("address byte malformed");

    read_order_a: assert property (
        s_restart |-> step == i2m_pkg::I2M_ADDRR && rd_mode && !nack_o)
        else $error("repeated start outside read");

    scl_high_a: assert property (
        $rose(scl_oe_o) && st == i2m_pkg::I2M_BYTE |->
        hi_cnt >= (QW+2)'(i2m_pkg::HIGH_MIN_CYC))
        else $error("clock high phase too short");

    pwrup_wait_a: assert property (
        $rose(busy_o) |-> pwr_cnt == PW'(PWRUP_CYC))
        else $error("access before power-up delay");

    both_low_a: assert property (
        both_low < BW'(BOTHLOW_CYC))
        else $error("both lines held low too long");
endmodule // i2m_master_ctrl
`default_nettype wire

// file: common/i2m_pkg.sv
/*
 * Constants and types for the two-wire register port master.
 * Assumes a 125 MHz system clock and one slave device sharing the bus.
 */
`default_nettype none
package i2m_pkg;
    // Bus address of the sensor and direction bit
    localparam logic [6:0] SLV_ADDR = 7'h15;
    localparam logic DIR_RD = 1'b1;
    localparam logic DIR_WR = 1'b0;
    // Register offsets in the sensor, one byte each
    localparam logic [7:0] REG_XOUT = 8'h00;
    localparam logic [7:0] REG_YOUT = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_DETECT = 8'h04;
    localparam logic [7:0] REG_CHIP_ID = 8'h08;
    // Bit slot of the acknowledge inside a byte
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] BITS_PER_BYTE = 4'h9;
    // Synchroniser reset levels {evt, sda, scl}
    localparam logic [2:0] SYNC_RST = 3'h3;
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_QTR_NS = 700;
    localparam int QTR_CYC = (T_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FSCL_MAX_KHZ = 400;
    localparam int T_SCL_MIN_NS = 1000000 / FSCL_MAX_KHZ;
    localparam int T_LOW_MIN_NS = 1300;
    localparam int T_HIGH_MIN_NS = 600;
    localparam int HIGH_MIN_CYC = (T_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_PWRUP_MS = 20;
    localparam int PWRUP_CYC = T_PWRUP_MS * 1000000 / CLK_PERIOD_NS;
    localparam int T_BOTHLOW_MS = 10;
    localparam int BOTHLOW_CYC = T_BOTHLOW_MS * 1000000 / CLK_PERIOD_NS;
    // Controller states
    typedef enum logic [4:0] {
        I2M_PWRUP = 5'h01,
        I2M_IDLE = 5'h02,
        I2M_START = 5'h04,
        I2M_BYTE = 5'h08,
        I2M_STOP = 5'h10
    } i2m_state_t;
    // Which byte of the transfer the wire carries
    typedef enum logic [4:0] {
        I2M_ADDRW = 5'h01,
        I2M_REGA = 5'h02,
        I2M_WDATA = 5'h04,
        I2M_ADDRR = 5'h08,
        I2M_RDATA = 5'h10
    } i2m_step_t;
endpackage
`default_nettype wire

// file: common/i2m_pins_if.sv
/*
 * Synchronised pin levels passed from the synchroniser to the master.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface i2m_pins_if;
    logic scl;
    logic sda;
    logic evt;
    modport src (output scl, output sda, output evt);
    modport dst (input scl, input sda, input evt);
endinterface
`default_nettype wire

// file: rtl/i2m_pin_sync.sv
/*
 * Two-flop synchronisers for the serial clock, data and event pins.
 * Assumes raw pin levels that are asynchronous to clk_sys_i.
 */
`timescale 1ns/1ps
`default_nettype none
module i2m_pin_sync (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Raw pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic evt_i,
    // Synchronised levels
    i2m_pins_if.src pins
);
    logic [2:0] meta;
    logic [2:0] sync;

    // First stage feeds the second only; idle bus reads high
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            meta <= i2m_pkg::SYNC_RST;
            sync <= i2m_pkg::SYNC_RST;
        end else begin
            meta <= {evt_i, sda_i, scl_i};
            sync <= meta;
        end
    end

    // Fan out to the interface
    assign pins.scl = sync[0];
    assign pins.sda = sync[1];
    assign pins.evt = sync[2];
endmodule // i2m_pin_sync
`default_nettype wire

// file: verif/i2m_slave_model.sv
/* Behavioural sensor slave for the two-wire bus, with a small register map.
   Assumes the bench resolves both lines as wired-AND with pull-ups. */
`timescale 1ns/1ps
`default_nettype none
module i2m_slave_model #(
    parameter logic [7:0] XV = 8'h5a,
    parameter logic [7:0] YV = 8'ha3,
    parameter logic [7:0] IDV = 8'h3c // Arbitrary id value
) (
    // Bus lines, clock is listen only
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_o,
    // Test controls and flags
    input wire logic refuse_i,
    input wire logic raise_i,
    output logic evt_o,
    output logic bad_o
);
    logic [7:0] wmem [0:255];
    logic [7:0] sh, ptr, txb, abyte;
    logic act = 1'h0, rdm = 1'h0, tx = 1'h0, mack = 1'h0;
    int cnt = 0, nb = 0;
    realtime t_r = 0, t_f = 0;
    initial sda_oe_o = 1'h0;
    initial evt_o = 1'h0;
    initial bad_o = 1'h0;
    // Event latch, only a status read clears it
    always @(posedge raise_i) evt_o = 1'h1;
    // Start: a mid-byte start means data moved under a high clock
    always @(negedge sda_i) if (scl_i) begin
        bad_o = bad_o | (act && cnt > 1);
        act = 1'h1;
        cnt = 0;
        nb = 0;
        tx = 1'h0;
        rdm = 1'h0;
        sda_oe_o = 1'h0;
    end
    // Stop: go quiet until the next start
    always @(posedge sda_i) if (scl_i) begin
        bad_o = bad_o | (act && cnt > 1);
        act = 1'h0;
        sda_oe_o = 1'h0;
    end
    // Sample at the rising clock; also police low time
    always @(posedge scl_i) begin
        bad_o = bad_o | (t_f > 0 && $realtime - t_f < i2m_pkg::T_LOW_MIN_NS);
        t_r = $realtime;
        if (act) begin
            cnt = cnt + 1;
            if (cnt <= 8) sh = {sh[6:0], sda_i};
            else mack = !sda_i;
        end
    end
    // Drive at the falling clock so data never moves while it is high
    always @(negedge scl_i) begin
        bad_o = bad_o | (t_r > 0 && $realtime - t_r < i2m_pkg::T_HIGH_MIN_NS);
        t_f = $realtime;
        if (act && cnt == 9) begin
            cnt = 0;
            sda_oe_o = 1'h0;
            if (tx && !mack) act = 1'h0;
            else if (rdm) begin
                tx = 1'h1;
                txb = (ptr == 8'h00) ? XV : (ptr == 8'h01) ? YV :
                      (ptr == 8'h02) ? {evt_o, 7'h12} : (ptr == 8'h08) ? IDV : 8'h00;
                if (ptr == 8'h02) evt_o = 1'h0;
                ptr = ptr + 8'h01;
                sda_oe_o = !txb[7];
            end
        end else if (act && cnt == 8 && !tx) begin
            if (nb == 0) begin
                abyte = sh;
                act = (sh[7:1] == 7'h15) && !refuse_i;
                rdm = sh[0];
            end else if (nb == 1) ptr = sh;
            else begin
                wmem[ptr] = sh;
                ptr = ptr + 8'h01;
            end
            nb = nb + 1;
            sda_oe_o = act;
        end else if (act && tx) sda_oe_o = (cnt == 8) ? 1'h0 : !txb[7-cnt];
    end
endmodule // i2m_slave_model
`default_nettype wire

// file: verif/tb_top.sv
/* Self-checking bench for the register port master against the slave model.
   Assumes open-drain pads, pull-ups modelled by the line assigns. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [7:0] XV = 8'h5a;
    localparam logic [7:0] YV = 8'ha3;
    localparam logic [7:0] IDV = 8'h3c;
    logic clk_sys_i = 1'h0, rst_i = 1'h1, cmd_valid_i = 1'h0, cmd_read_i = 1'h0;
    logic [7:0] cmd_reg_i = 8'h00, wr_data_i = 8'h00, rd_data_o;
    logic [3:0] cmd_len_i = 4'h0;
    logic refuse = 1'h0, raise = 1'h0;
    logic cmd_ready_o, busy_o, wr_take_o, rd_valid_o, done_o, nack_o;
    logic scl_o, scl_oe_o, sda_o, sda_oe_o, evt_o, mdl_oe, evt_pin, bad;
    wire logic scl_w;
    wire logic sda_w;
    logic [7:0] wbuf [0:3];
    logic [7:0] rbuf [0:3];
    int widx, nrd, err_count = 0, samples_checked = 0;
    // Wired-AND lines with pull-ups
    assign scl_w = !scl_oe_o;
    assign sda_w = !(sda_oe_o || mdl_oe);
    always #(i2m_pkg::CLK_PERIOD_NS / 2) clk_sys_i = !clk_sys_i;
    // Short power-up hold-off keeps the run brief
    i2m_master_ctrl #(.PWRUP_CYC(200)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .cmd_valid_i(cmd_valid_i), .cmd_read_i(cmd_read_i), .cmd_reg_i(cmd_reg_i),
        .cmd_len_i(cmd_len_i), .wr_data_i(wr_data_i), .cmd_ready_o(cmd_ready_o),
        .busy_o(busy_o), .wr_take_o(wr_take_o), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .done_o(done_o), .nack_o(nack_o), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .evt_pin_i(evt_pin), .evt_o(evt_o));
    i2m_slave_model #(.XV(XV), .YV(YV), .IDV(IDV)) mdl (.scl_i(scl_w), .sda_i(sda_w),
        .sda_oe_o(mdl_oe), .refuse_i(refuse), .raise_i(raise), .evt_o(evt_pin),
        .bad_o(bad));
    task automatic final_report();
        if (err_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // One command, feeding write bytes and collecting read bytes until done
    task automatic run_cmd(input logic rd, input logic [7:0] rg, input logic [3:0] len);
        int n;
        widx = 0;
        nrd = 0;
        wr_data_i = wbuf[0];
        cmd_read_i = rd;
        cmd_reg_i = rg;
        cmd_len_i = len;
        cmd_valid_i = 1'h1;
        n = 0;
        while (cmd_ready_o !== 1'h1 && n < 1000) begin
            tick(1);
            n++;
        end
        tick(1);
        cmd_valid_i = 1'h0;
        chk1(busy_o, 1'h1);
        chk1(cmd_ready_o, 1'h0);
        n = 0;
        while (done_o !== 1'h1 && n < 60000) begin
            if (wr_take_o === 1'h1) widx++;
            wr_data_i = wbuf[widx[1:0]];
            if (rd_valid_o === 1'h1) rbuf[nrd[1:0]] = rd_data_o;
            if (rd_valid_o === 1'h1) nrd++;
            tick(1);
            n++;
        end
        chk1(done_o, 1'h1);
        chk1(busy_o, 1'h0);
    endtask
    task automatic t_powerup();
        tick(100);
        chk1(cmd_ready_o, 1'h0);
        chk1(scl_w, 1'h1);
        chk1(sda_w, 1'h1);
        chk1(scl_o, 1'h0);
        chk1(sda_o, 1'h0);
        tick(120);
        chk1(cmd_ready_o, 1'h1);
    endtask
    task automatic t_write();
        wbuf[0] = 8'ha5;
        wbuf[1] = 8'h3c;
        run_cmd(1'h0, 8'h04, 4'h2);
        chk8(mdl.abyte, 8'h2a);
        chk8(mdl.wmem[8'h04], 8'ha5);
        chk8(mdl.wmem[8'h05], 8'h3c);
        chk1(nack_o, 1'h0);
        // Pointer-only write: register byte, then stop
        run_cmd(1'h0, 8'h08, 4'h0);
        chk8(mdl.ptr, 8'h08);
        chk1(nack_o, 1'h0);
    endtask
    task automatic t_read_evt();
        raise = 1'h1;
        tick(4);
        chk1(evt_o, 1'h1);
        run_cmd(1'h1, 8'h00, 4'h2);
        chk8(rbuf[0], XV);
        chk8(rbuf[1], YV);
        chk8(mdl.abyte, 8'h2b);
        chk1(mdl.mack, 1'h0);
        chk1(evt_o, 1'h1);
        run_cmd(1'h1, 8'h02, 4'h1);
        chk8(rbuf[0], {1'h1, 7'h12});
        raise = 1'h0;
        tick(4);
        chk1(evt_o, 1'h0);
    endtask
    // Refused address, then a one-byte read straight after
    task automatic t_refuse();
        refuse = 1'h1;
        wbuf[0] = 8'h77;
        run_cmd(1'h0, 8'h04, 4'h1);
        chk1(nack_o, 1'h1);
        chk8(mdl.wmem[8'h04], 8'ha5);
        chk1(sda_w, 1'h1);
        refuse = 1'h0;
        run_cmd(1'h1, 8'h08, 4'h0);
        chk8(rbuf[0], IDV);
        chk8(nrd[7:0], 8'h01);
        chk1(nack_o, 1'h0);
        chk1(bad, 1'h0);
    endtask
    initial begin
        tick(10);
        rst_i = 1'h0;
        t_powerup();
        t_write();
        t_read_evt();
        t_refuse();
        final_report();
    end
    // Watchdog about 15 percent past the expected run length
    initial begin
        #640000;
        err_count++;
        final_report();
    end
endmodule // tb_top
`default_nettype wire
